// ==== verilog/tbt_pkg.sv ====
package tbt_pkg;

  // ==========================================================
  // bus and register map
  // ==========================================================
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] IFLAG_OFF = 10'h001;
  localparam logic [ADDR_W-1:0] TMODE_OFF = 10'h008;
  localparam logic [ADDR_W-1:0] IMASK_OFF = 10'h040;
  localparam logic [ADDR_W-1:0] COUNT_OFF = 10'h041;
  localparam logic [ADDR_W-1:0] PSS_OFF   = 10'h042;
  localparam logic [ADDR_W-1:0] PSW_OFF   = 10'h043;

  localparam int IFLAG_BIT = 2;

  // ==========================================================
  // widths and reset values
  // ==========================================================
  localparam int PSS_W  = 11;
  localparam int PSW_W  = 5;
  localparam int TCA_W  = 8;
  localparam int TMODE_W = 4;
  localparam int XDIV_W = 3;

  localparam logic [TMODE_W-1:0] TMODE_RST = 4'h0;
  localparam logic [TCA_W-1:0]   TCA_RST   = 8'h00;
  localparam logic [XDIV_W-1:0]  XDIV_TOP  = 3'h7;
  localparam logic [1:0]         XHALF_TOP = 2'h3;

  // ==========================================================
  // mode register fields
  // ==========================================================
  localparam int TM_TB_BIT = 3;
  localparam logic [2:0] TM_CLR_CODE  = 3'h7;
  localparam logic [2:0] TM_HALF_CODE = 3'h4;

  // tap k divides by 2^(k+1)
  localparam int PSS_TAP [0:7] = '{10, 9, 8, 6, 4, 2, 1, 0};
  localparam int PSW_TAP [0:3] = '{4, 3, 2, 0};
  localparam int SER_TAP [0:5] = '{10, 8, 6, 4, 2, 0};
  localparam logic [2:0] SER_SYS_CODE = 3'h6;

  // ==========================================================
  // types
  // ==========================================================
  typedef enum logic [2:0] {
    OPM_ACTIVE    = 3'b000,
    OPM_STANDBY   = 3'b001,
    OPM_SUBACTIVE = 3'b010,
    OPM_WATCH     = 3'b011,
    OPM_STOP      = 3'b100
  } tbt_opmode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } tbt_bus_req_t;

endpackage

// ==== verilog/tbt_prescaler.sv ====
`timescale 1ns/100ps
module tbt_prescaler
  import tbt_pkg::*;
#(
  parameter int WIDTH = 11
) (
  input  wire logic             clk,   // system clock
  input  wire logic             rst_n, // sync reset, active low
  input  wire logic             inc,   // count enable pulse
  input  wire logic             clr,   // synchronous clear
  output logic [WIDTH-1:0]      count, // current count
  output logic [WIDTH-1:0]      tap    // carry pulse per stage
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  generate
    if (WIDTH < 1 || WIDTH > 16) begin : g_bad
      $error("tbt_prescaler: WIDTH out of range");
    end
  endgenerate

  // ==========================================================
  // stage carries
  // ==========================================================
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_tap
      assign tap[i] = inc & (&count_reg[i:0]);
    end
  endgenerate

  assign count_next = clr ? '0 : (inc ? count_reg + 1'b1 : count_reg);
  assign count      = count_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

// ==== verilog/tbt_timebase_timer.sv ====
// The plain strobed port was decided locally.
`timescale 1ns/100ps
module tbt_timebase_timer
  import tbt_pkg::*;
(
  input  wire logic              clk,             // 40 MHz system clock
  input  wire logic              rst_n,           // sync reset, active low
  input  wire tbt_bus_req_t      bus,             // register request
  output logic [DATA_W-1:0]      rdata,           // read data, cycle after
  input  wire tbt_opmode_t       op_mode,         // core operating state
  input  wire logic              subclock_crystal_input, // 32 kHz pin
  input  wire logic [2:0]        serial_div_sel,  // serial clock select
  output logic                   serial_clk_tick, // serial clock pulse
  output logic                   timer_a_ovf,     // overflow pulse
  output logic [TCA_W-1:0]       timer_a_count,   // timer count
  output logic                   timer_a_irq      // interrupt level
);

  // ==========================================================
  // declarations
  // ==========================================================
  logic              x_s1_reg;
  logic              x_s2_reg;
  logic              x_s3_reg;
  logic              x_edge;

  logic [XDIV_W-1:0] xdiv_reg;
  logic [XDIV_W-1:0] xdiv_next;

  logic [PSS_W-1:0]  pss_count;
  logic [PSS_W-1:0]  pss_tap;
  logic [PSW_W-1:0]  psw_count;
  logic [PSW_W-1:0]  psw_tap;

  logic              pss_run;
  logic              pss_src;
  logic              pss_inc;
  logic              psw_run;
  logic              psw_inc;
  logic              half_tick;

  logic [TMODE_W-1:0] timer_a_mode_select_reg;
  logic [TMODE_W-1:0] tmode_next;
  logic               timebase_select_bit;
  logic [2:0]         tsel;

  logic              wr_tmode;
  logic              wr_flag;
  logic              wr_mask;
  logic              sw_clr;

  logic              pss_sel_tick;
  logic              psw_sel_tick;
  logic              tca_tick;

  logic [TCA_W-1:0]  tca_reg;
  logic [TCA_W-1:0]  tca_next;
  logic              tca_at_top;
  logic              ovf;
  logic              ovf_reg;

  logic              timer_a_irq_flag_reg;
  logic              flag_next;
  logic              flag_w1c;
  logic              mask_reg;
  logic              mask_next;
  logic              irq_reg;
  logic              irq_next;

  logic              ser_tick;
  logic              ser_reg;

  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // ==========================================================
  // elaboration checks
  // ==========================================================
  generate
    if (TMODE_W != 4) begin : g_bad_mode
      $error("tbt_timebase_timer: mode register must be four bits");
    end
    if (TCA_W > DATA_W || PSW_W > DATA_W) begin : g_bad_read
      $error("tbt_timebase_timer: counter wider than read data");
    end
    if (PSS_W < DATA_W) begin : g_bad_pss
      $error("tbt_timebase_timer: system prescaler narrower than read data");
    end
    if (PSS_TAP[0] >= PSS_W || SER_TAP[0] >= PSS_W) begin : g_bad_ptap
      $error("tbt_timebase_timer: system tap beyond prescaler width");
    end
    if (PSW_TAP[0] >= PSW_W) begin : g_bad_wtap
      $error("tbt_timebase_timer: watch tap beyond prescaler width");
    end
    if (IFLAG_BIT >= DATA_W || TM_TB_BIT >= TMODE_W) begin : g_bad_bit
      $error("tbt_timebase_timer: field position outside its register");
    end
  endgenerate

  // ==========================================================
  // crystal pin synchroniser and edge
  // ==========================================================
  // third stage only feeds the edge detector
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      x_s1_reg <= 1'b0;
      x_s2_reg <= 1'b0;
      x_s3_reg <= 1'b0;
    end else begin
      x_s1_reg <= subclock_crystal_input;
      x_s2_reg <= x_s1_reg;
      x_s3_reg <= x_s2_reg;
    end
  end

  assign x_edge = x_s2_reg & ~x_s3_reg;

  // ==========================================================
  // register decode
  // ==========================================================
  assign wr_tmode = bus.wr & (bus.addr == TMODE_OFF);
  assign wr_flag  = bus.wr & (bus.addr == IFLAG_OFF);
  assign wr_mask  = bus.wr & (bus.addr == IMASK_OFF);

  assign sw_clr = wr_tmode & (bus.wdata[TMODE_W-1:1] == TM_CLR_CODE);

  assign tmode_next = wr_tmode ? bus.wdata[TMODE_W-1:0]
                               : timer_a_mode_select_reg;

  assign timebase_select_bit = timer_a_mode_select_reg[TM_TB_BIT];
  assign tsel                = timer_a_mode_select_reg[2:0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_a_mode_select_reg <= TMODE_RST;
    end else begin
      timer_a_mode_select_reg <= tmode_next;
    end
  end

  // ==========================================================
  // system prescaler
  // ==========================================================
  // halted in watch and stop
  assign pss_run = (op_mode != OPM_WATCH) & (op_mode != OPM_STOP);

  assign pss_src = (op_mode == OPM_SUBACTIVE) ? x_edge : 1'b1;
  assign pss_inc = pss_run & pss_src;

  tbt_prescaler #(
    .WIDTH (PSS_W)
  ) u_system_prescaler (
    .clk   (clk),
    .rst_n (rst_n),
    .inc   (pss_inc),
    .clr   (1'b0),
    .count (pss_count),
    .tap   (pss_tap)
  );

  // ==========================================================
  // watch prescaler with crystal divide by eight
  // ==========================================================
  // runs in every state but stop
  assign psw_run = (op_mode != OPM_STOP);

  assign xdiv_next = sw_clr ? '0
                   : ((psw_run & x_edge) ? xdiv_reg + 1'b1 : xdiv_reg);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xdiv_reg <= '0;
    end else begin
      xdiv_reg <= xdiv_next;
    end
  end

  // one step per eight crystal edges
  assign psw_inc   = psw_run & x_edge & (xdiv_reg == XDIV_TOP);
  assign half_tick = psw_run & x_edge & (xdiv_reg[1:0] == XHALF_TOP);

  tbt_prescaler #(
    .WIDTH (PSW_W)
  ) u_watch_prescaler (
    .clk   (clk),
    .rst_n (rst_n),
    .inc   (psw_inc),
    .clr   (sw_clr),
    .count (psw_count),
    .tap   (psw_tap)
  );

  // ==========================================================
  // timer clock selection
  // ==========================================================
  // system tap per mode
  assign pss_sel_tick = pss_tap[PSS_TAP[tsel]];

  always_comb begin
    psw_sel_tick = 1'b0;
    case (tsel)
      3'h0:         psw_sel_tick = psw_tap[PSW_TAP[0]];
      3'h1:         psw_sel_tick = psw_tap[PSW_TAP[1]];
      3'h2:         psw_sel_tick = psw_tap[PSW_TAP[2]];
      3'h3:         psw_sel_tick = psw_tap[PSW_TAP[3]];
      TM_HALF_CODE: psw_sel_tick = half_tick;
      default:      psw_sel_tick = 1'b0;
    endcase
  end

  assign tca_tick = timebase_select_bit ? psw_sel_tick : pss_sel_tick;

  // ==========================================================
  // timer counter
  // ==========================================================
  assign tca_at_top = &tca_reg;

  // same in both modes
  // no overflow on the clearing write
  assign ovf = tca_tick & tca_at_top & ~sw_clr;

  assign tca_next = sw_clr   ? TCA_RST
                  : tca_tick ? tca_reg + 1'b1
                  : tca_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tca_reg <= TCA_RST;
      ovf_reg <= 1'b0;
    end else begin
      tca_reg <= tca_next;
      ovf_reg <= ovf;
    end
  end

  // ==========================================================
  // interrupt flag and mask
  // ==========================================================
  assign flag_w1c = wr_flag & bus.wdata[IFLAG_BIT];

  // overflow sets flag, set beats clear
  assign flag_next = (timer_a_irq_flag_reg & ~flag_w1c) | ovf;
  assign mask_next = wr_mask ? bus.wdata[IFLAG_BIT] : mask_reg;
  assign irq_next  = flag_next & mask_next;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_a_irq_flag_reg <= 1'b0;
      mask_reg             <= 1'b0;
      irq_reg              <= 1'b0;
    end else begin
      timer_a_irq_flag_reg <= flag_next;
      mask_reg             <= mask_next;
      irq_reg              <= irq_next;
    end
  end

  // ==========================================================
  // serial clock tap
  // ==========================================================
  // serial divider selection
  always_comb begin
    ser_tick = 1'b0;
    case (serial_div_sel)
      3'h0:         ser_tick = pss_tap[SER_TAP[0]];
      3'h1:         ser_tick = pss_tap[SER_TAP[1]];
      3'h2:         ser_tick = pss_tap[SER_TAP[2]];
      3'h3:         ser_tick = pss_tap[SER_TAP[3]];
      3'h4:         ser_tick = pss_tap[SER_TAP[4]];
      3'h5:         ser_tick = pss_tap[SER_TAP[5]];
      SER_SYS_CODE: ser_tick = pss_inc;
      default:      ser_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ser_reg <= 1'b0;
    end else begin
      ser_reg <= ser_tick;
    end
  end

  // ==========================================================
  // read path
  // ==========================================================
  // mode register is write-only and reads zero
  always_comb begin
    rd_mux = '0;
    case (bus.addr)
      IFLAG_OFF: rd_mux[IFLAG_BIT] = timer_a_irq_flag_reg;
      IMASK_OFF: rd_mux[IFLAG_BIT] = mask_reg;
      COUNT_OFF: rd_mux = tca_reg;
      PSS_OFF:   rd_mux = pss_count[DATA_W-1:0];
      PSW_OFF:   rd_mux[PSW_W-1:0] = psw_count;
      default:   rd_mux = '0;
    endcase
  end

  assign rdata_next = bus.rd ? rd_mux : '0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign rdata           = rdata_reg;
  assign serial_clk_tick = ser_reg;
  assign timer_a_ovf     = ovf_reg;
  assign timer_a_count   = tca_reg;
  assign timer_a_irq     = irq_reg;

endmodule

// ==== bench/tbt_timebase_timer_monitor.sv ====
`timescale 1ns/100ps
module tbt_timebase_timer_monitor
  import tbt_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire tbt_bus_req_t      bus,
  input wire logic [DATA_W-1:0] rdata,
  input wire tbt_opmode_t       op_mode,
  input wire logic              subclock_crystal_input,
  input wire logic [2:0]        serial_div_sel,
  input wire logic              serial_clk_tick,
  input wire logic              timer_a_ovf,
  input wire logic [TCA_W-1:0]  timer_a_count,
  input wire logic              timer_a_irq
);
  // ====================
  // shadow of written state
  logic [3:0] mode_q;
  logic       mask_q;
  wire mode_wr = bus.wr && bus.addr == TMODE_OFF;
  wire clr_wr  = mode_wr && bus.wdata[3:1] == TM_CLR_CODE;
  wire irq_wr  = bus.wr && (bus.addr == IFLAG_OFF || bus.addr == IMASK_OFF);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= TMODE_RST;
      mask_q <= 1'b0;
    end else begin
      if (mode_wr) mode_q <= bus.wdata[3:0];
      if (bus.wr && bus.addr == IMASK_OFF) mask_q <= bus.wdata[IFLAG_BIT];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_tick;
    !$stable(timer_a_count);
  endsequence
  sequence s_wrap;
    timer_a_count == 8'h00 && $past(timer_a_count) == 8'hff && !$past(clr_wr);
  endsequence
  AST_OVF_AFTER_WRAP: assert property (s_wrap |-> timer_a_ovf)
    else $error("overflow missing after wrap");
  AST_OVF_ONLY_WRAP: assert property (timer_a_ovf |->
    timer_a_count == 8'h00 && $past(timer_a_count) == 8'hff)
    else $error("overflow without wrap");
  AST_COUNT_STEP: assert property (s_tick |->
    timer_a_count == 8'($past(timer_a_count) + 8'h01) || $past(clr_wr))
    else $error("count moved by other than one");
  AST_CLR_HOLDS: assert property (clr_wr |=>
    (timer_a_count == 8'h00) [*2] ##1 (timer_a_count == 8'h00 || $past(mode_wr, 2)))
    else $error("count not held at zero after clear");
  AST_SYS_STOPPED: assert property ((op_mode == OPM_WATCH || op_mode == OPM_STOP)
    && !mode_q[TM_TB_BIT] && !mode_wr |=> $stable(timer_a_count))
    else $error("count moved with system prescaler stopped");
  AST_RATE_DIV2: assert property (mode_q == 4'h7 && op_mode == OPM_ACTIVE
    && !mode_wr ##0 s_tick |=> $stable(timer_a_count) ##1 s_tick)
    else $error("divide by two rate wrong");
  AST_IRQ_ON_OVF: assert property (timer_a_ovf && mask_q && !irq_wr
    |-> ##[0:2] timer_a_irq)
    else $error("irq missing after overflow");
  AST_IRQ_STICKY: assert property (timer_a_irq && !irq_wr && !$past(irq_wr)
    |=> timer_a_irq)
    else $error("irq dropped without clear");
  AST_RDATA_IDLE: assert property (!$past(bus.rd) || $past(bus.addr) == TMODE_OFF
    |-> rdata == 8'h00)
    else $error("read data not zero");
endmodule

bind tbt_timebase_timer tbt_timebase_timer_monitor mon (
  .clk(clk),
  .rst_n(rst_n),
  .bus(bus),
  .rdata(rdata),
  .op_mode(op_mode),
  .subclock_crystal_input(subclock_crystal_input),
  .serial_div_sel(serial_div_sel),
  .serial_clk_tick(serial_clk_tick),
  .timer_a_ovf(timer_a_ovf),
  .timer_a_count(timer_a_count),
  .timer_a_irq(timer_a_irq)
);

// ==== bench/tbt_xtal_model.sv ====
`timescale 1ns/100ps
module tbt_xtal_model (
  input  wire logic clk,  // bench clock
  input  wire logic run,  // oscillator running
  output logic      xtal  // crystal level
);
  // ====================
  // crystal, period of eight clocks, holds level when stopped
  logic [2:0] ph = 3'h0;
  always_ff @(posedge clk) begin
    if (run) ph <= ph + 3'h1;
  end
  assign xtal = ph[2];
endmodule

// ==== bench/tbt_timebase_timer_bench.sv ====
`timescale 1ns/100ps
module tbt_timebase_timer_bench
  import tbt_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  tbt_bus_req_t      bus = '0;
  tbt_opmode_t       op_mode = OPM_ACTIVE;
  logic [2:0]        sel = 3'h7;
  logic              run = 1'b1;
  logic              xtal;
  logic [DATA_W-1:0] rdata;
  logic              stick;
  logic              ovf;
  logic              irq;
  logic [TCA_W-1:0]  cnt;
  logic [31:0]       seed = 32'h9270;
  logic [7:0]        v;
  logic [7:0]        w;
  logic [9:0]        ra [4] = '{COUNT_OFF, TMODE_OFF, IFLAG_OFF, 10'h3ff};
  int                n_mismatch = 0;
  int                num_checks = 0;
  int                i;
  int                k;

  initial begin
    forever #12.5 clk = ~clk;
  end

  tbt_xtal_model osc (.clk(clk), .run(run), .xtal(xtal));
  tbt_timebase_timer dut (
    .clk(clk),
    .rst_n(rst_n),
    .bus(bus),
    .rdata(rdata),
    .op_mode(op_mode),
    .subclock_crystal_input(xtal),
    .serial_div_sel(sel),
    .serial_clk_tick(stick),
    .timer_a_ovf(ovf),
    .timer_a_count(cnt),
    .timer_a_irq(irq)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] ser_exp(input int s);
    if (s == 7) return 16'h0000;
    if (s == 6) return 16'h0040;
    return 16'h0040 >> (11 - 2 * s);
  endfunction
  // timer steps in 256 clocks for system modes 3 to 7
  function automatic logic [7:0] rate_exp(input int m);
    case (m)
      3: return 8'h02;
      4: return 8'h08;
      5: return 8'h20;
      6: return 8'h40;
      default: return 8'h80;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // two reads taken gap+2 edges apart, returns their difference
  task automatic dlt(input logic [9:0] a, input int gap, output logic [7:0] d);
    logic [7:0] x;
    rd(a, x);
    repeat (gap) @(posedge clk);
    rd(a, d);
    d = d - x;
  endtask
  task automatic wait_ovf(input int lim);
    k = 0;
    while (ovf !== 1'b1) begin
      @(negedge clk);
      k++;
      if (k > lim) begin
        n_mismatch++;
        summarize();
      end
    end
  endtask

  // ====================
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], v);
      chk("reset read", v, 8'h00);
    end
    dlt(PSS_OFF, 30, v);
    chk("pss active", v, 8'h20);
    @(posedge clk) op_mode <= OPM_WATCH;
    dlt(PSS_OFF, 30, v);
    chk("pss watch", v, 8'h00);
    dlt(PSW_OFF, 62, v);
    chk("psw watch", v, 8'h01);
    @(posedge clk) op_mode <= OPM_STOP;
    dlt(PSW_OFF, 62, v);
    chk("psw stop", v, 8'h00);
    @(posedge clk) op_mode <= OPM_SUBACTIVE;
    run <= 1'b0;
    repeat (4) @(posedge clk);
    dlt(PSS_OFF, 30, v);
    chk("pss sub idle", v, 8'h00);
    @(posedge clk) run <= 1'b1;
    dlt(PSS_OFF, 62, v);
    chk("pss sub", v, 8'h08);
    @(posedge clk) op_mode <= OPM_ACTIVE;
    for (i = 3; i < 8; i++) begin
      @(posedge clk) sel <= i[2:0];
      repeat (4) @(posedge clk);
      k = 0;
      repeat (64) begin
        @(negedge clk);
        k += stick;
      end
      chk("serial ticks", k[15:0], ser_exp(i));
    end
    for (i = 3; i < 8; i++) begin
      wr(TMODE_OFF, i[7:0]);
      dlt(COUNT_OFF, 254, v);
      chk("mode rate", v, rate_exp(i));
    end
    wr(TMODE_OFF, 8'h0b);
    dlt(COUNT_OFF, 254, v);
    chk("watch rate", v, 8'h02);
    wr(IMASK_OFF, 8'h04);
    wr(TMODE_OFF, 8'h0e);
    wr(TMODE_OFF, 8'h07);
    wait_ovf(600);
    chk("ovf time", k > 500 && k < 530, 1'b1);
    repeat (2) @(negedge clk);
    chk("irq", irq, 1'b1);
    wr(IFLAG_OFF, 8'h04);
    repeat (2) @(negedge clk);
    chk("irq clr", irq, 1'b0);
    wr(IMASK_OFF, 8'h00);
    wait_ovf(600);
    repeat (2) @(negedge clk);
    chk("irq masked", irq, 1'b0);
    rd(IFLAG_OFF, v);
    chk("flag", v[IFLAG_BIT], 1'b1);
    for (i = 14; i < 16; i++) begin
      wr(TMODE_OFF, 8'h07);
      repeat (20) @(posedge clk);
      wr(TMODE_OFF, i[7:0]);
      rd(COUNT_OFF, v);
      chk("count clr", v, 8'h00);
      chk("count pin", cnt, 8'h00);
      rd(PSW_OFF, v);
      chk("psw clr", v, 8'h00);
    end
    wr(TMODE_OFF, 8'h0d);
    dlt(COUNT_OFF, 20, v);
    chk("no clock", v, 8'h00);
    wr(IFLAG_OFF, 8'h04);
    wr(IMASK_OFF, 8'h04);
    wr(TMODE_OFF, 8'h0e);
    wr(TMODE_OFF, 8'h0c);
    wait_ovf(9000);
    chk("timebase time", k > 8100 && k < 8300, 1'b1);
    rd(IFLAG_OFF, v);
    chk("timebase flag", v[IFLAG_BIT], 1'b1);
    for (i = 0; i < 40; i++) begin
      w = 8'(rnd());
      @(posedge clk) op_mode <= w[0] ? OPM_STANDBY : OPM_ACTIVE;
      wr(TMODE_OFF, {4'h0, w[7:4]});
      rd(TMODE_OFF, v);
      chk("mode write only", v, 8'h00);
      rd({2'b11, w}, v);
      chk("unmapped", v, 8'h00);
      repeat (w[6:0]) @(posedge clk);
    end
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(COUNT_OFF, v);
    chk("count reset", v, 8'h00);
    chk("irq reset", irq, 1'b0);
    summarize();
  end
endmodule
